// ---- logic/scmp_pkg.sv ----
// package: register map, field layout and timing constants of the supply comparator
`default_nettype none
package scmp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SCMP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SCMP_OFF_INSEL  = 8'h04;
  localparam logic [7:0] SCMP_OFF_STATUS = 8'h08;
  localparam logic [7:0] SCMP_OFF_IEN    = 8'h0C;
  localparam logic [7:0] SCMP_OFF_IF     = 8'h10;
  localparam logic [7:0] SCMP_OFF_IFS    = 8'h14;
  localparam logic [7:0] SCMP_OFF_IFC    = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         SCMP_B_HALF     = 30;
  localparam int         SCMP_B_BIAS_LO  = 24;
  localparam int         SCMP_B_FALL     = 17;
  localparam int         SCMP_B_RISE     = 16;
  localparam int         SCMP_B_WARM_LO  = 8;
  localparam int         SCMP_B_HYST     = 4;
  localparam int         SCMP_B_IDLE     = 2;
  localparam int         SCMP_B_EN       = 0;
  localparam int         SCMP_B_LOW_POWER_REFERENCE    = 8;
  localparam int         SCMP_B_THR_LO   = 0;
  localparam int         SCMP_B_OUT      = 1;
  localparam int         SCMP_B_ACT      = 0;
  localparam int         SCMP_B_WARMUP   = 1;
  localparam int         SCMP_B_EDGE     = 0;
  localparam logic [3:0] SCMP_BIAS_RST   = 4'h7;
  localparam logic [5:0] SCMP_THR_RST    = 6'h00;
  localparam logic [2:0] SCMP_WARM_RST   = 3'h0;
  // shortest warm-up, as log2 of cycles
  localparam int         SCMP_WARM_MIN_LOG2 = 2;
  localparam int         SCMP_CNT_W      = 10;

  typedef struct packed {
    logic       bias_halving;
    logic [3:0] bias_level_code;
    logic       falling_sense;
    logic       rising_sense;
    logic [2:0] warmup_length;
    logic       hysteresis_on;
    logic       idle_output_level;
    logic       enable;
  } scmp_ctrl_t;

  typedef struct packed {
    logic       warmup;
    logic       edge_evt;
  } scmp_irq_t;

  typedef enum logic [1:0] {SCMP_OFF, SCMP_WARMING, SCMP_ACTIVE} scmp_state_t;

endpackage
`default_nettype wire

// ---- logic/scmp_regs.sv ----
// supply comparator register bank with warm-up sequencer and edge detection
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module scmp_regs
  import scmp_pkg::*;
(
  input  wire logic        pclk,                 // peripheral clock, 40 MHz
  input  wire logic        presetn,              // async reset, active low
  input  wire logic        psel,                 // apb select
  input  wire logic        penable,              // apb access phase
  input  wire logic        pwrite,               // apb write
  input  wire logic [7:0]  paddr,                // apb byte address
  input  wire logic [31:0] pwdata,               // apb write data
  output logic      [31:0] prdata,               // apb read data
  output logic             pready,               // apb ready
  output logic             pslverr,              // apb error, unmapped address
  input  wire logic        comparator_raw,       // asynchronous analog comparator output
  output logic             analog_enable,        // powers the analog comparator
  output logic             bias_halving,         // halve bias current
  output logic      [3:0]  bias_level_code,      // bias current level
  output logic             hysteresis_on,        // 20 mV hysteresis
  output logic             low_power_reference,  // low-power reference mode
  output logic      [5:0]  threshold_code,       // supply trigger level
  output logic             comparator_output,    // synchronised or idle level
  output logic             comparator_active,    // warmed up and enabled
  output logic             irq                   // interrupt request
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  assign wr_en  = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = addr_hit(paddr, SCMP_OFF_CTRL) || addr_hit(paddr, SCMP_OFF_INSEL) ||
                  addr_hit(paddr, SCMP_OFF_STATUS) || addr_hit(paddr, SCMP_OFF_IEN) ||
                  addr_hit(paddr, SCMP_OFF_IF) || addr_hit(paddr, SCMP_OFF_IFS) ||
                  addr_hit(paddr, SCMP_OFF_IFC);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // control and input selection registers
  // ----------------------------------------------------------------
  scmp_ctrl_t  ctrl_reg;
  logic        low_power_reference_reg;
  logic [5:0]  thr_reg;
  scmp_irq_t   ien_reg;
  scmp_irq_t   if_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.bias_halving      <= 1'b0;
      ctrl_reg.bias_level_code   <= SCMP_BIAS_RST;
      ctrl_reg.falling_sense     <= 1'b0;
      ctrl_reg.rising_sense      <= 1'b0;
      ctrl_reg.warmup_length     <= SCMP_WARM_RST;
      ctrl_reg.hysteresis_on     <= 1'b0;
      ctrl_reg.idle_output_level <= 1'b0;
      ctrl_reg.enable            <= 1'b0;
    end else if (wr_en && addr_hit(paddr, SCMP_OFF_CTRL)) begin
      ctrl_reg.bias_halving      <= pwdata[SCMP_B_HALF];
      ctrl_reg.bias_level_code   <= pwdata[SCMP_B_BIAS_LO +: 4];
      ctrl_reg.falling_sense     <= pwdata[SCMP_B_FALL];
      ctrl_reg.rising_sense      <= pwdata[SCMP_B_RISE];
      ctrl_reg.warmup_length     <= pwdata[SCMP_B_WARM_LO +: 3];
      ctrl_reg.hysteresis_on     <= pwdata[SCMP_B_HYST];
      ctrl_reg.idle_output_level <= pwdata[SCMP_B_IDLE];
      ctrl_reg.enable            <= pwdata[SCMP_B_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_reference_reg <= 1'b0;
      thr_reg   <= SCMP_THR_RST;
    end else if (wr_en && addr_hit(paddr, SCMP_OFF_INSEL)) begin
      low_power_reference_reg <= pwdata[SCMP_B_LOW_POWER_REFERENCE];
      thr_reg   <= pwdata[SCMP_B_THR_LO +: 6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_reg <= '0;
    end else if (wr_en && addr_hit(paddr, SCMP_OFF_IEN)) begin
      ien_reg.warmup   <= pwdata[SCMP_B_WARMUP];
      ien_reg.edge_evt <= pwdata[SCMP_B_EDGE];
    end
  end

  assign analog_enable       = ctrl_reg.enable;
  assign bias_halving        = ctrl_reg.bias_halving;
  assign bias_level_code     = ctrl_reg.bias_level_code;
  assign hysteresis_on       = ctrl_reg.hysteresis_on;
  assign low_power_reference = low_power_reference_reg;
  assign threshold_code      = thr_reg;

  // ----------------------------------------------------------------
  // warm-up sequencer
  // ----------------------------------------------------------------
  scmp_state_t           state_reg;
  logic [SCMP_CNT_W-1:0] warm_cnt_reg;
  logic [SCMP_CNT_W-1:0] warm_len;
  logic                  warm_done;

  // 4 << code cycles
  assign warm_len  = SCMP_CNT_W'(1) << (SCMP_WARM_MIN_LOG2 + int'(ctrl_reg.warmup_length));
  assign warm_done = (state_reg == SCMP_WARMING) && (warm_cnt_reg == warm_len - SCMP_CNT_W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= SCMP_OFF;
      warm_cnt_reg <= '0;
    end else begin
      case (state_reg)
        SCMP_OFF: begin
          warm_cnt_reg <= '0;
          if (ctrl_reg.enable) begin
            state_reg <= SCMP_WARMING;
          end
        end
        SCMP_WARMING: begin
          if (!ctrl_reg.enable) begin
            state_reg <= SCMP_OFF;
          end else if (warm_done) begin
            state_reg <= SCMP_ACTIVE;
          end else begin
            warm_cnt_reg <= warm_cnt_reg + SCMP_CNT_W'(1);
          end
        end
        SCMP_ACTIVE: begin
          if (!ctrl_reg.enable) begin
            state_reg <= SCMP_OFF;
          end
        end
        default: state_reg <= SCMP_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output synchroniser and edge detection
  // ----------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic out_reg;
  logic out_next;
  logic act_reg;
  logic rise_evt;
  logic fall_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= comparator_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign out_next = (state_reg == SCMP_ACTIVE) ? sync2_reg : ctrl_reg.idle_output_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      act_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      act_reg <= (state_reg == SCMP_ACTIVE);
    end
  end

  assign rise_evt = ctrl_reg.rising_sense && out_next && !out_reg;
  assign fall_evt = ctrl_reg.falling_sense && !out_next && out_reg;
  assign comparator_output = out_reg;
  assign comparator_active = act_reg;

  // ----------------------------------------------------------------
  // interrupt flags: hardware and set win over clear
  // ----------------------------------------------------------------
  logic ifs_wr;
  logic ifc_wr;
  assign ifs_wr = wr_en && addr_hit(paddr, SCMP_OFF_IFS);
  assign ifc_wr = wr_en && addr_hit(paddr, SCMP_OFF_IFC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_reg <= '0;
    end else begin
      if (warm_done || (ifs_wr && pwdata[SCMP_B_WARMUP])) begin
        if_reg.warmup <= 1'b1;
      end else if (ifc_wr && pwdata[SCMP_B_WARMUP]) begin
        if_reg.warmup <= 1'b0;
      end
      if (rise_evt || fall_evt || (ifs_wr && pwdata[SCMP_B_EDGE])) begin
        if_reg.edge_evt <= 1'b1;
      end else if (ifc_wr && pwdata[SCMP_B_EDGE]) begin
        if_reg.edge_evt <= 1'b0;
      end
    end
  end

  assign irq = |(if_reg & ien_reg);

  // ----------------------------------------------------------------
  // read mux, captured into prdata at the end of the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    if (addr_hit(paddr, SCMP_OFF_CTRL)) begin
      rdata_next[SCMP_B_HALF]           = ctrl_reg.bias_halving;
      rdata_next[SCMP_B_BIAS_LO +: 4]  = ctrl_reg.bias_level_code;
      rdata_next[SCMP_B_FALL]           = ctrl_reg.falling_sense;
      rdata_next[SCMP_B_RISE]           = ctrl_reg.rising_sense;
      rdata_next[SCMP_B_WARM_LO +: 3]  = ctrl_reg.warmup_length;
      rdata_next[SCMP_B_HYST]           = ctrl_reg.hysteresis_on;
      rdata_next[SCMP_B_IDLE]           = ctrl_reg.idle_output_level;
      rdata_next[SCMP_B_EN]             = ctrl_reg.enable;
    end else if (addr_hit(paddr, SCMP_OFF_INSEL)) begin
      rdata_next[SCMP_B_LOW_POWER_REFERENCE]          = low_power_reference_reg;
      rdata_next[SCMP_B_THR_LO +: 6]   = thr_reg;
    end else if (addr_hit(paddr, SCMP_OFF_STATUS)) begin
      rdata_next[SCMP_B_OUT]            = out_reg;
      rdata_next[SCMP_B_ACT]            = act_reg;
    end else if (addr_hit(paddr, SCMP_OFF_IEN)) begin
      rdata_next[SCMP_B_WARMUP]         = ien_reg.warmup;
      rdata_next[SCMP_B_EDGE]           = ien_reg.edge_evt;
    end else if (addr_hit(paddr, SCMP_OFF_IF)) begin
      rdata_next[SCMP_B_WARMUP]         = if_reg.warmup;
      rdata_next[SCMP_B_EDGE]           = if_reg.edge_evt;
    end
  end

  // sampled at the end of the setup cycle so prdata comes from a flop and
  // still meets the zero-wait access; cleared again after the access
  logic [31:0] prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (rd_setup) begin
      prdata_reg <= rdata_next;
    end else begin
      prdata_reg <= '0;
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_enable_rise;
    $rose(ctrl_reg.enable);
  endsequence

  sequence s_min_warm;
    !act_reg [*5];
  endsequence

  chk_warm_min_len: assert property (@(posedge pclk) disable iff (!presetn)
    s_enable_rise |-> s_min_warm)
    else $error("comparator active before shortest warm-up");

  chk_warm_max_len: assert property (@(posedge pclk) disable iff (!presetn)
    (s_enable_rise ##0 (ctrl_reg.warmup_length == 3'h0)) ##1 ctrl_reg.enable [*5]
      |-> ##1 act_reg)
    else $error("comparator not active after four-cycle warm-up");

  chk_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
    !act_reg |-> comparator_output == $past(ctrl_reg.idle_output_level))
    else $error("output not idle level while inactive");

  chk_active_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg.enable |-> ##2 !act_reg)
    else $error("active status held after disable");

  chk_warm_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(act_reg) |-> if_reg.warmup)
    else $error("warm-up flag missing at activation");

  chk_edge_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (rise_evt || fall_evt) |=> if_reg.edge_evt)
    else $error("edge flag not set on sensed edge");

  chk_clear_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (ifc_wr && pwdata[SCMP_B_EDGE] && !ifs_wr && !rise_evt && !fall_evt) |=> !if_reg.edge_evt)
    else $error("edge flag survived clear");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == ((if_reg.warmup && ien_reg.warmup) || (if_reg.edge_evt && ien_reg.edge_evt)))
    else $error("interrupt request mismatch");

  chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == SCMP_ACTIVE) [*3] |-> comparator_output == $past(comparator_raw, 3))
    else $error("synchronised output latency wrong");

  sequence s_edge_quiet;
    !rise_evt && !fall_evt && !(ifs_wr && pwdata[SCMP_B_EDGE]) &&
      !(ifc_wr && pwdata[SCMP_B_EDGE]);
  endsequence

  sequence s_warm_quiet;
    !warm_done && !(ifs_wr && pwdata[SCMP_B_WARMUP]) &&
      !(ifc_wr && pwdata[SCMP_B_WARMUP]);
  endsequence

  chk_rise_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(comparator_output) && $past(ctrl_reg.rising_sense)) |-> if_reg.edge_evt)
    else $error("edge flag missing after rising output");

  chk_fall_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(comparator_output) && $past(ctrl_reg.falling_sense)) |-> if_reg.edge_evt)
    else $error("edge flag missing after falling output");

  chk_edge_set: assert property (@(posedge pclk) disable iff (!presetn)
    (ifs_wr && pwdata[SCMP_B_EDGE]) |=> if_reg.edge_evt)
    else $error("edge flag not set by set register");

  chk_warm_set: assert property (@(posedge pclk) disable iff (!presetn)
    warm_done |=> if_reg.warmup)
    else $error("warm-up flag not set when warm-up ends");

  chk_warm_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ifc_wr && pwdata[SCMP_B_WARMUP] && !warm_done) |=> !if_reg.warmup)
    else $error("warm-up flag survived clear");

  chk_edge_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_edge_quiet |=> $stable(if_reg.edge_evt))
    else $error("edge flag changed without cause");

  chk_warm_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_warm_quiet |=> $stable(if_reg.warmup))
    else $error("warm-up flag changed without cause");

  chk_off_state: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg.enable |=> (state_reg == SCMP_OFF))
    else $error("sequencer not off while disabled");

endmodule
`default_nettype wire

// ---- sim/test_supply_comparator_regs.sv ----
// self-checking testbench for the supply comparator register bank
`timescale 1ns/10ps
`default_nettype none
module test_supply_comparator_regs
  import scmp_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        comparator_raw;
  logic        analog_enable;
  logic        bias_halving;
  logic [3:0]  bias_level_code;
  logic        hysteresis_on;
  logic        low_power_reference;
  logic [5:0]  threshold_code;
  logic        comparator_output;
  logic        comparator_active;
  logic        irq;
  int          fail_count;
  int          cmp_count;
  int          k;

  scmp_regs i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_raw(comparator_raw), .analog_enable(analog_enable),
    .bias_halving(bias_halving), .bias_level_code(bias_level_code),
    .hysteresis_on(hysteresis_on), .low_power_reference(low_power_reference),
    .threshold_code(threshold_code), .comparator_output(comparator_output),
    .comparator_active(comparator_active), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // reporting and comparison
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master: entered just after a rising edge, leaves one idle cycle
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x,
                    input logic xerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, x, r);
    chk_bit(nm, xerr, e);
  endtask

  // counts falling edges until the chosen output reaches v
  task automatic wait_port(input bit act, input logic v, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((act ? comparator_active : comparator_output) !== v && n < 2000);
    if (n >= 2000) begin
      fail_count++;
      print_verdict();
    end
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    rd("ctrl", SCMP_OFF_CTRL, 32'h0700_0000, 1'b0);
    rd("insel", SCMP_OFF_INSEL, 32'h0000_0000, 1'b0);
    rd("status", SCMP_OFF_STATUS, 32'h0000_0000, 1'b0);
    rd("ien", SCMP_OFF_IEN, 32'h0000_0000, 1'b0);
    rd("flags", SCMP_OFF_IF, 32'h0000_0000, 1'b0);
    chk("bias_port", 32'h7, {28'h0, bias_level_code});
  endtask

  task automatic s_fields;
    wr(SCMP_OFF_CTRL, 32'h4F03_0714);
    rd("ctrl", SCMP_OFF_CTRL, 32'h4F03_0714, 1'b0);
    chk_bit("halving", 1'b1, bias_halving);
    chk("bias_port", 32'hF, {28'h0, bias_level_code});
    chk_bit("hyst", 1'b1, hysteresis_on);
    chk_bit("enable", 1'b0, analog_enable);
    chk_bit("idle_out", 1'b1, comparator_output);
    wr(SCMP_OFF_STATUS, 32'h0000_0003);
    rd("status", SCMP_OFF_STATUS, 32'h0000_0002, 1'b0);
    wr(SCMP_OFF_INSEL, 32'h0000_013F);
    rd("insel", SCMP_OFF_INSEL, 32'h0000_013F, 1'b0);
    chk("thr_port", 32'h3F, {26'h0, threshold_code});
    chk_bit("low_power_reference", 1'b1, low_power_reference);
    wr(SCMP_OFF_INSEL, 32'h0000_0000);
    wr(SCMP_OFF_CTRL, 32'h0000_0000);
  endtask

  task automatic s_warm;
    for (int c = 0; c < 8; c++) begin
      wr(SCMP_OFF_CTRL, 32'h0000_0000);
      wr(SCMP_OFF_IFC, 32'h0000_0003);
      // idle output level stays high during warm-up
      wr(SCMP_OFF_CTRL, (32'(c) << 8) | 32'h0000_0005);
      @(negedge pclk);
      chk_bit("warm_act", 1'b0, comparator_active);
      chk_bit("warm_out", 1'b1, comparator_output);
      chk_bit("enable", 1'b1, analog_enable);
      wait_port(1'b1, 1'b1, k);
      chk("warm_len", (32'd4 << c) + 32'd1, 32'(k));
      chk_bit("act_out", 1'b0, comparator_output);
      rd("flags", SCMP_OFF_IF, 32'h0000_0002, 1'b0);
      rd("status", SCMP_OFF_STATUS, 32'h0000_0001, 1'b0);
    end
    wr(SCMP_OFF_CTRL, 32'h0000_0000);
  endtask

  task automatic s_edge(input logic [31:0] cfg, input logic [31:0] on_rise,
                        input logic [31:0] on_fall);
    wr(SCMP_OFF_CTRL, cfg);
    wait_port(1'b1, 1'b1, k);
    wr(SCMP_OFF_IFC, 32'h0000_0003);
    comparator_raw <= 1'b1;
    wait_port(1'b0, 1'b1, k);
    chk("sync_lat", 32'd4, 32'(k));
    rd("flags_r", SCMP_OFF_IF, on_rise, 1'b0);
    rd("status", SCMP_OFF_STATUS, 32'h0000_0003, 1'b0);
    wr(SCMP_OFF_IFC, 32'h0000_0001);
    comparator_raw <= 1'b0;
    wait_port(1'b0, 1'b0, k);
    rd("flags_f", SCMP_OFF_IF, on_fall, 1'b0);
    wr(SCMP_OFF_CTRL, 32'h0000_0000);
  endtask

  task automatic s_flags;
    wr(SCMP_OFF_IEN, 32'h0000_0003);
    rd("ien", SCMP_OFF_IEN, 32'h0000_0003, 1'b0);
    wr(SCMP_OFF_IFC, 32'h0000_0003);
    chk_bit("irq", 1'b0, irq);
    wr(SCMP_OFF_IFS, 32'h0000_0002);
    rd("flags", SCMP_OFF_IF, 32'h0000_0002, 1'b0);
    chk_bit("irq", 1'b1, irq);
    wr(SCMP_OFF_IFS, 32'h0000_0000);
    wr(SCMP_OFF_IF, 32'h0000_0000);
    wr(SCMP_OFF_IFC, 32'h0000_0001);
    rd("flags", SCMP_OFF_IF, 32'h0000_0002, 1'b0);
    wr(SCMP_OFF_IFC, 32'h0000_0002);
    rd("flags", SCMP_OFF_IF, 32'h0000_0000, 1'b0);
    wr(SCMP_OFF_IEN, 32'h0000_0001);
    wr(SCMP_OFF_IFS, 32'h0000_0002);
    chk_bit("irq_mask", 1'b0, irq);
    wr(SCMP_OFF_IFS, 32'h0000_0001);
    chk_bit("irq", 1'b1, irq);
    wr(SCMP_OFF_IFC, 32'h0000_0003);
    chk_bit("irq", 1'b0, irq);
    wr(8'h1C, 32'h0000_0001);
    rd("unmapped", 8'h1C, 32'h0000_0000, 1'b1);
    rd("ien", SCMP_OFF_IEN, 32'h0000_0001, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    comparator_raw = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_fields();
    s_warm();
    s_edge(32'h0001_0001, 32'h0000_0001, 32'h0000_0000);
    s_edge(32'h0002_0001, 32'h0000_0000, 32'h0000_0001);
    s_flags();
    print_verdict();
  end
endmodule
`default_nettype wire
